// File: amb_flash_dev.sv
// Notes on behaviour
// - Bank MSB set selects 4-byte addressing, bank bits ignored.
// - Opcode 16h reads bank, 17h writes one byte.
// - Bank MSB clear: 3-byte addressing, bank selects segment.
// - Dedicated 4-byte commands carry full address always.
// - Hardware, software reset or power cycle exit 4-byte.
// - Opcode F0h performs a software reset.
// - Host exits continuous read mode before other resets.
// - Status write needs prior 06h enable, else rejected.
// - Sector map header: region 00h, config 00h, descriptors set.
// - Top byte of map header dword reads FFh.
`default_nettype none
module amb_flash_dev (
  amb_spi_if.dev spi,
  input wire logic rst_n,
  input wire logic [7:0] rd_data,
  output logic [31:0] rd_addr,
  output logic rd_stb,
  output logic four_byte_mode,
  output logic [7:0] bank_value,
  output logic [7:0] sr1_value
);
  ////////////////////////////////////////////////////////////////////////////
  // The whole device runs on the serial clock. Frame state is cleared while
  // chip select is high, because the clock stands still between frames and
  // no edge would be there to clear it.
  typedef struct packed {
    logic [7:0] bank;
    logic wel;
    logic [7:0] sr1;
    logic [31:0] rd_addr;
  } amb_keep_t;

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [2:0] byte_idx;
    logic [7:0] op;
    logic [6:0] sh;
    logic [31:0] addr;
    logic [7:0] out_sr;
    logic miso;
    logic rd_stb;
  } amb_frame_t;

  amb_keep_t keep_ff;
  amb_keep_t nxt_keep;
  amb_frame_t frame_ff;
  amb_frame_t nxt_frame;
  logic frame_rst_n;
  logic [7:0] byte_in;
  logic [31:0] addr_in;

  assign frame_rst_n = rst_n & ~spi.cs_n;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] addr_len(input logic [7:0] op, input logic four);
    if (op == amb_pkg::OP_FREAD4 || (op == amb_pkg::OP_FREAD && four)) begin
      addr_len = 3'd4;
    end else begin
      addr_len = 3'd3;
    end
  endfunction

  function automatic logic [31:0] eff_addr(input logic [7:0] op, input logic [7:0] bank,
                                           input logic [31:0] a);
    // In 3-byte mode bit 31 is never reached: the segment field is seven bits.
    if (op == amb_pkg::OP_FREAD4 || bank[amb_pkg::BANK_MODE_BIT]) begin
      eff_addr = a;
    end else begin
      eff_addr = {1'b0, bank[6:0], a[23:0]};
    end
  endfunction

  function automatic logic [7:0] status_byte(input amb_keep_t k);
    status_byte = k.sr1;
    status_byte[amb_pkg::SR1_WEL_BIT] = k.wel;
  endfunction

  // Only array reads fetch from the user side; parameter reads never do.
  function automatic logic reads_array(input logic [7:0] op);
    reads_array = (op == amb_pkg::OP_FREAD || op == amb_pkg::OP_FREAD4);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_keep = keep_ff;
    nxt_frame = frame_ff;
    byte_in = {frame_ff.sh, spi.mosi};
    addr_in = {frame_ff.addr[23:0], byte_in};
    nxt_frame.rd_stb = 1'b0;
    nxt_frame.bit_cnt = frame_ff.bit_cnt + 3'd1;
    nxt_frame.sh = {frame_ff.sh[5:0], spi.mosi};
    nxt_frame.miso = frame_ff.out_sr[7];
    nxt_frame.out_sr = {frame_ff.out_sr[6:0], 1'b0};
    // Every decision waits for the eighth rise of a byte, when byte_in is whole.
    if (frame_ff.bit_cnt == 3'd7) begin
      if (frame_ff.byte_idx != 3'd7) begin
        nxt_frame.byte_idx = frame_ff.byte_idx + 3'd1;
      end
      if (frame_ff.byte_idx == 3'd0) begin
        nxt_frame.op = byte_in;
        case (byte_in)
          amb_pkg::OP_WREN: begin
            nxt_keep.wel = 1'b1;
          end
          amb_pkg::OP_WRDI: begin
            nxt_keep.wel = 1'b0;
          end
          amb_pkg::OP_SRST: begin
            // Status bits are kept: a soft reset only returns bank and latch.
            nxt_keep.bank = amb_pkg::BANK_RST;
            nxt_keep.wel = 1'b0;
          end
          amb_pkg::OP_EXIT: begin
            // There is no continuous read mode here, so this frame does nothing.
            nxt_frame.out_sr = 8'h00;
          end
          amb_pkg::OP_RDSR1: begin
            nxt_frame.out_sr = status_byte(keep_ff);
          end
          amb_pkg::OP_RDBANK: begin
            nxt_frame.out_sr = keep_ff.bank;
          end
          default: begin
            nxt_frame.out_sr = 8'h00;
          end
        endcase
      end else begin
        case (frame_ff.op)
          amb_pkg::OP_WRBANK: begin
            // Only the first data byte counts; any further bytes are dropped.
            if (frame_ff.byte_idx == 3'd1) begin
              nxt_keep.bank = byte_in;
            end
          end
          amb_pkg::OP_WRSR1: begin
            // One status write spends the latch; an unlatched write is dropped.
            if (frame_ff.byte_idx == 3'd1 && keep_ff.wel) begin
              nxt_keep.sr1 = byte_in;
              nxt_keep.wel = 1'b0;
            end
          end
          amb_pkg::OP_RDSR1: begin
            nxt_frame.out_sr = status_byte(keep_ff);
          end
          amb_pkg::OP_RDBANK: begin
            nxt_frame.out_sr = keep_ff.bank;
          end
          amb_pkg::OP_FREAD, amb_pkg::OP_FREAD4, amb_pkg::OP_SFDP: begin
            if (frame_ff.byte_idx <= addr_len(frame_ff.op, keep_ff.bank[amb_pkg::BANK_MODE_BIT]))
            begin
              nxt_frame.addr = addr_in;
              if (frame_ff.byte_idx ==
                  addr_len(frame_ff.op, keep_ff.bank[amb_pkg::BANK_MODE_BIT])) begin
                // The strobe leads the data by one byte time: the dummy byte
                // gives the user side a whole byte to fetch.
                nxt_frame.rd_stb = reads_array(frame_ff.op);
                nxt_keep.rd_addr = eff_addr(frame_ff.op, keep_ff.bank, addr_in);
              end
            end else begin
              if (frame_ff.op == amb_pkg::OP_SFDP) begin
                nxt_frame.out_sr = amb_pkg::sfdp_byte(frame_ff.addr[7:0]);
              end else begin
                nxt_frame.out_sr = rd_data;
              end
              nxt_frame.addr = frame_ff.addr + 32'd1;
              nxt_frame.rd_stb = reads_array(frame_ff.op);
              nxt_keep.rd_addr = eff_addr(frame_ff.op, keep_ff.bank, frame_ff.addr + 32'd1);
            end
          end
          default: begin
            nxt_frame.out_sr = 8'h00;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank, latch and status outlive chip select; frame_rst_n never clears them, rst_n does.
  always_ff @(posedge spi.sck or negedge rst_n) begin
    if (!rst_n) begin
      keep_ff <= '{bank: amb_pkg::BANK_RST, wel: 1'b0, sr1: amb_pkg::SR1_RST,
                   rd_addr: 32'h0000_0000};
    end else begin
      keep_ff <= nxt_keep;
    end
  end

  always_ff @(posedge spi.sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      frame_ff <= '0;
    end else begin
      frame_ff <= nxt_frame;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every output is a flip-flop or a plain decode of one, never of mosi.
  assign spi.miso = frame_ff.miso;
  assign rd_addr = keep_ff.rd_addr;
  assign rd_stb = frame_ff.rd_stb;
  assign four_byte_mode = keep_ff.bank[amb_pkg::BANK_MODE_BIT];
  assign bank_value = keep_ff.bank;
  assign sr1_value = status_byte(keep_ff);
endmodule
`default_nettype wire

// File: amb_pkg.sv
`default_nettype none
package amb_pkg;
  // Serial opcodes.
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_RDBANK = 8'h16;
  localparam logic [7:0] OP_WRBANK = 8'h17;
  localparam logic [7:0] OP_SRST = 8'hf0;
  localparam logic [7:0] OP_EXIT = 8'hff;
  localparam logic [7:0] OP_FREAD = 8'h0b;
  localparam logic [7:0] OP_FREAD4 = 8'h0c;
  localparam logic [7:0] OP_SFDP = 8'h5a;

  // Bank register and status register layout.
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam int BANK_MODE_BIT = 7;
  localparam logic [7:0] SR1_RST = 8'h00;
  localparam int SR1_WEL_BIT = 1;

  // Host register map, byte addresses on the AHB-Lite bus.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FOUR_BIT = 1;
  localparam int STAT_RX_LSB = 8;

  // Host link timing: one serial bit takes SCK_DIV system clocks.
  localparam int SCK_DIV = 8;
  localparam logic [2:0] SCK_LAST = 3'(SCK_DIV - 1);
  localparam logic [2:0] GAP_CYC = 3'd4;

  // Discoverable parameter bytes around the sector map header.
  function automatic logic [7:0] sfdp_byte(input logic [7:0] a);
    case (a)
      8'h3c: sfdp_byte = 8'hf0;
      8'h3d: sfdp_byte = 8'h28;
      8'h3e: sfdp_byte = 8'hfa;
      8'h3f: sfdp_byte = 8'ha8;
      8'h40: sfdp_byte = 8'hff;
      8'h41: sfdp_byte = 8'h00;
      8'h42: sfdp_byte = 8'h00;
      8'h43: sfdp_byte = 8'hff;
      default: sfdp_byte = 8'hff;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: amb_spi_if.sv
`default_nettype none
interface amb_spi_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev (input sck, input cs_n, input mosi, output miso);
  modport host (output sck, output cs_n, output mosi, input miso);
endinterface
`default_nettype wire

// File: amb_spi_host.sv
`default_nettype none
module amb_spi_host (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  amb_spi_if.host spi
);
  typedef enum logic [1:0] {H_IDLE, H_XFER, H_GAP} amb_hstate_t;

  typedef struct packed {
    amb_hstate_t state;
    logic [2:0] cnt;
    logic [5:0] bits;
    logic [55:0] tx;
    logic [7:0] rx;
    logic sck;
    logic cs_n;
    logic mosi;
    logic pend_rst;
    logic four;
    logic [2:0] gap;
    logic [31:0] rdata;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] addr;
    logic [7:0] wdata;
    logic miso_s1;
    logic miso_s2;
  } amb_host_t;

  amb_host_t s_ff;
  amb_host_t nxt_s;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [61:0] frame(input logic [7:0] op, input logic four,
                                        input logic [31:0] a, input logic [7:0] wd);
    case (op)
      amb_pkg::OP_WRBANK, amb_pkg::OP_WRSR1: frame = {6'd16, op, wd, 40'h0};
      amb_pkg::OP_RDBANK, amb_pkg::OP_RDSR1: frame = {6'd16, op, 48'h0};
      amb_pkg::OP_FREAD4: frame = {6'd56, op, a, 16'h0};
      amb_pkg::OP_FREAD: begin
        if (four) begin
          frame = {6'd56, op, a, 16'h0};
        end else begin
          frame = {6'd48, op, a[23:0], 24'h0};
        end
      end
      amb_pkg::OP_SFDP: frame = {6'd48, op, a[23:0], 24'h0};
      default: frame = {6'd8, op, 48'h0};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_s = s_ff;
    nxt_s.miso_s1 = spi.miso;
    nxt_s.miso_s2 = s_ff.miso_s1;
    nxt_s.ap_wr = 1'b0;
    if (hsel && htrans[1] && hready) begin
      nxt_s.ap_wr = hwrite;
      nxt_s.ap_addr = haddr[7:0];
      case (haddr[7:0])
        amb_pkg::REG_ADDR: nxt_s.rdata = s_ff.addr;
        amb_pkg::REG_WDATA: nxt_s.rdata = {24'h0, s_ff.wdata};
        amb_pkg::REG_STAT: nxt_s.rdata = {16'h0, s_ff.rx, 6'h0, s_ff.four,
                                          s_ff.state != H_IDLE};
        default: nxt_s.rdata = 32'h0000_0000;
      endcase
    end
    case (s_ff.state)
      H_IDLE: begin
        if (s_ff.ap_wr && s_ff.ap_addr == amb_pkg::REG_CMD) begin
          nxt_s.state = H_XFER;
          nxt_s.cs_n = 1'b0;
          nxt_s.cnt = 3'd0;
          if (hwdata[7:0] == amb_pkg::OP_SRST) begin
            // Exit continuous read first, so the reset opcode is not taken
            // as address bits by a device still in that mode.
            nxt_s.pend_rst = 1'b1;
            {nxt_s.bits, nxt_s.tx} = frame(amb_pkg::OP_EXIT, s_ff.four, s_ff.addr, s_ff.wdata);
          end else begin
            {nxt_s.bits, nxt_s.tx} = frame(hwdata[7:0], s_ff.four, s_ff.addr, s_ff.wdata);
            if (hwdata[7:0] == amb_pkg::OP_WRBANK) begin
              nxt_s.four = s_ff.wdata[amb_pkg::BANK_MODE_BIT];
            end
          end
        end else if (s_ff.ap_wr && s_ff.ap_addr == amb_pkg::REG_ADDR) begin
          nxt_s.addr = hwdata;
        end else if (s_ff.ap_wr && s_ff.ap_addr == amb_pkg::REG_WDATA) begin
          nxt_s.wdata = hwdata[7:0];
        end
      end
      H_XFER: begin
        nxt_s.cnt = s_ff.cnt + 3'd1;
        nxt_s.sck = nxt_s.cnt[2];
        if (s_ff.cnt == 3'd0) begin
          nxt_s.mosi = s_ff.tx[55];
        end
        if (s_ff.cnt == amb_pkg::SCK_LAST) begin
          nxt_s.rx = {s_ff.rx[6:0], s_ff.miso_s2};
          nxt_s.tx = {s_ff.tx[54:0], 1'b0};
          nxt_s.bits = s_ff.bits - 6'd1;
          if (s_ff.bits == 6'd1) begin
            nxt_s.state = H_GAP;
            nxt_s.cs_n = 1'b1;
            nxt_s.mosi = 1'b0;
            nxt_s.gap = amb_pkg::GAP_CYC;
          end
        end
      end
      H_GAP: begin
        nxt_s.gap = s_ff.gap - 3'd1;
        if (s_ff.gap == 3'd1) begin
          if (s_ff.pend_rst) begin
            nxt_s.pend_rst = 1'b0;
            nxt_s.four = 1'b0;
            nxt_s.state = H_XFER;
            nxt_s.cs_n = 1'b0;
            nxt_s.cnt = 3'd0;
            {nxt_s.bits, nxt_s.tx} = frame(amb_pkg::OP_SRST, 1'b0, s_ff.addr, s_ff.wdata);
          end else begin
            nxt_s.state = H_IDLE;
          end
        end
      end
      default: begin
        nxt_s.state = H_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '{state: H_IDLE, cs_n: 1'b1, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_ff.rdata;
  assign spi.sck = s_ff.sck;
  assign spi.cs_n = s_ff.cs_n;
  assign spi.mosi = s_ff.mosi;
endmodule
`default_nettype wire

// File: amb_link_props.sv
`default_nettype none
module amb_link_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  // Counts serial bits modulo one byte, so a cut-off byte is caught at frame end.
  logic [2:0] bit_cnt_ff;
  logic sck_q_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_ff <= 3'h0;
      sck_q_ff <= 1'b0;
    end else begin
      sck_q_ff <= sck;
      if (cs_n) begin
        bit_cnt_ff <= 3'h0;
      end else if (sck && !sck_q_ff) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("serial clock moved outside a frame");
  AST_MISO_IDLE: assert property (cs_n |-> !miso)
    else $error("device data line not idle outside a frame");
  AST_GAP: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("frame gap shorter than four cycles");
  AST_SCK_HIGH: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("serial clock high phase has wrong length");
  AST_MOSI_HOLD: assert property (sck |-> $stable(mosi))
    else $error("host data changed while serial clock high");
  AST_MISO_HOLD: assert property (!cs_n && !$past(cs_n) && !$rose(sck) |-> $stable(miso))
    else $error("device data changed away from a clock rise");
  AST_WHOLE_BYTES: assert property ($rose(cs_n) |-> bit_cnt_ff == 3'h0)
    else $error("frame ended inside a byte");
  AST_LEAD_IN: assert property ($fell(cs_n) |-> !sck ##[1:16] sck)
    else $error("first serial clock edge late or early");
  cover property ($rose(cs_n));
  cover property ($rose(sck) ##1 miso);
  cover property (!cs_n && mosi ##1 sck);
endmodule
`default_nettype wire

// File: tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] rd_data = 8'h00;
  logic hreadyout, hresp, rd_stb, four_byte_mode;
  logic [31:0] hrdata, rd_addr;
  logic [7:0] bank_value, sr1_value;
  logic [7:0] sfdp_exp [8] = '{8'hf0, 8'h28, 8'hfa, 8'ha8, 8'hff, 8'h00, 8'h00, 8'hff};
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int stb_count = 0;
  amb_spi_if spi ();
  amb_spi_host amb_spi_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .spi(spi));
  amb_flash_dev amb_flash_dev_inst (.spi(spi), .rst_n(rst_n), .rd_data(rd_data),
    .rd_addr(rd_addr), .rd_stb(rd_stb), .four_byte_mode(four_byte_mode),
    .bank_value(bank_value), .sr1_value(sr1_value));
  amb_link_props amb_link_props_inst (.clk_sys(clk_sys), .rst_n(rst_n), .sck(spi.sck),
    .cs_n(spi.cs_n), .mosi(spi.mosi), .miso(spi.miso));
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] mem_of(input logic [31:0] a);
    return a[31:24] ^ a[23:16] ^ a[15:8] ^ a[7:0];
  endfunction
  function automatic logic [31:0] eff_addr(input logic [7:0] b, input logic [31:0] a);
    return b[7] ? a : {1'b0, b[6:0], a[23:0]};
  endfunction
  task automatic end_sim();
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // Polls busy over the bus, so the frame gap is paced by the host alone.
  task automatic cmd(input logic [7:0] op, input logic [31:0] a, input logic [7:0] wd,
    output logic [7:0] rx);
    logic [31:0] r;
    ahb(1'b1, amb_pkg::REG_ADDR, a, r);
    ahb(1'b1, amb_pkg::REG_WDATA, {24'h0, wd}, r);
    ahb(1'b1, amb_pkg::REG_CMD, {24'h0, op}, r);
    do ahb(1'b0, amb_pkg::REG_STAT, 32'h0, r); while (r[0] !== 1'b0);
    rx = r[15:8];
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  // Counts fetch strobes from the device, one per byte taken from the user side.
  always @(posedge rd_stb) begin
    stb_count++;
  end
  always @(posedge clk_sys) begin
    rd_data <= mem_of(rd_addr);
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    logic [7:0] b, rx;
    logic [31:0] a, r;
    // Starting from unknown makes a real falling edge, so the async resets fire.
    rst_n <= 1'b0;
    void'($urandom(32'h8c8c8f38));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk(32'(bank_value), 32'h0);
    ahb(1'b0, 8'h10, 32'h0, r);
    chk(r, 32'h0);
    chk(32'(hresp), 32'h0);
    for (int i = 0; i < 6; i++) begin
      b = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : 8'($urandom);
      cmd(amb_pkg::OP_WRBANK, 32'h0, b, rx);
      chk(32'(bank_value), 32'(b));
      chk(32'(four_byte_mode), 32'(b[7]));
      cmd(amb_pkg::OP_RDBANK, 32'h0, 8'h00, rx);
      chk(32'(rx), 32'(b));
      a = $urandom;
      cmd(amb_pkg::OP_FREAD, a, 8'h00, rx);
      chk(32'(rx), 32'(mem_of(eff_addr(b, a))));
      stb_count = 0;
      cmd(amb_pkg::OP_FREAD4, a, 8'h00, rx);
      chk(32'(rx), 32'(mem_of(a)));
      chk(32'(stb_count), 32'h3);
      chk(rd_addr, a + 32'd2);
    end
    cmd(amb_pkg::OP_WRSR1, 32'h0, 8'h1c, rx);
    chk(32'(sr1_value), 32'(amb_pkg::SR1_RST));
    cmd(amb_pkg::OP_WREN, 32'h0, 8'h00, rx);
    cmd(amb_pkg::OP_RDSR1, 32'h0, 8'h00, rx);
    chk(32'(rx[1]), 32'h1);
    cmd(amb_pkg::OP_WRBANK, 32'h0, 8'h80 | 8'($urandom), rx);
    cmd(amb_pkg::OP_SRST, 32'h0, 8'h00, rx);
    chk(32'(bank_value), 32'h0);
    chk(32'(sr1_value[1]), 32'h0);
    ahb(1'b0, amb_pkg::REG_STAT, 32'h0, r);
    chk(32'(r[1]), 32'h0);
    a = $urandom;
    cmd(amb_pkg::OP_FREAD, a, 8'h00, rx);
    chk(32'(rx), 32'(mem_of({8'h00, a[23:0]})));
    cmd(amb_pkg::OP_WREN, 32'h0, 8'h00, rx);
    cmd(amb_pkg::OP_WRSR1, 32'h0, 8'h1c, rx);
    chk(32'(sr1_value), 32'h1c);
    for (int i = 0; i < 8; i++) begin
      cmd(amb_pkg::OP_SFDP, 32'h3c + 32'(i), 8'h00, rx);
      chk(32'(rx), 32'(sfdp_exp[i]));
    end
    cmd(amb_pkg::OP_WRBANK, 32'h0, 8'hff, rx);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk(32'(four_byte_mode), 32'h0);
    chk(32'(bank_value), 32'h0);
    chk(32'(sr1_value), 32'(amb_pkg::SR1_RST));
    end_sim();
  end
endmodule
`default_nettype wire
